/* File: pkg/dccu_pkg.sv */
// package for the data cache control unit: geometry, function codes, fault codes, status layout
package dccu_pkg;
	localparam int SETS         = 256;
	localparam int SET_BITS     = 8;
	localparam int WORDS        = 4;
	localparam int WORD_BITS    = 2;
	localparam int TAG_BITS     = 20;
	localparam logic [7:0] FN_DISABLE   = 8'h00;
	localparam logic [7:0] FN_ENABLE    = 8'h01;
	localparam logic [7:0] FN_INVAL     = 8'h02;
	localparam logic [7:0] FN_COHERE    = 8'h03;
	localparam logic [7:0] FN_STATUS    = 8'h04;
	localparam logic [7:0] FN_STORE     = 8'h06;
	localparam logic [1:0] FLT_NONE     = 2'h0;
	localparam logic [1:0] FLT_TYPE     = 2'h1;
	localparam logic [1:0] FLT_OPERAND  = 2'h2;
	localparam logic [3:0] ST_ATOM_LOG  = 4'h2;
	localparam logic [3:0] ST_LINE_LOG  = 4'h2;
	localparam logic [3:0] ST_SETS_LOG  = 4'h8;
	localparam logic [11:0] ST_WAYS_M1  = 12'h000;
	localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
	localparam logic [31:0] ALIGN_MASK  = 32'h0000_0003;
	localparam logic [15:0] MAX_SET     = 16'h00ff;
	localparam logic [2:0] SLOT_SETDATA = 3'h0;
	localparam logic [2:0] SLOT_TAG     = 3'h1;
	localparam logic [2:0] SLOT_VALID   = 3'h2;
	localparam logic [2:0] SLOT_LAST    = 3'h6;
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_WRITE = 4'b0010,
		S_FIX   = 4'b0100,
		S_DONE  = 4'b1000
	} dccu_state_e;
endpackage

/* File: src/dccu_top.sv */
// data cache control unit: executes the cache-management instruction
`timescale 1ns/1ps
`default_nettype none
module dccu_top
	import dccu_pkg::*;
(
	input  wire logic        sys_clk,        // 20 MHz core clock
	input  wire logic        rst,            // synchronous reset, high
	input  wire logic        issue,          // one-cycle instruction issue
	input  wire logic [1:0]  execution_mode_field, // current mode
	input  wire logic [31:0] function_code_operand, // function select
	input  wire logic [31:0] target_address_operand, // store address
	input  wire logic [31:0] src_dst_in,     // set range operand
	input  wire logic        prior_idle,     // pipeline has no earlier ops pending
	input  wire logic        fill_valid,     // line fill from memory
	input  wire logic [31:0] fill_addr,      // fill word address
	input  wire logic [31:0] fill_data,      // fill word data
	input  wire logic        mem_ready,      // external memory takes write
	output logic             busy,           // holds later operations
	output logic             done,           // one-cycle completion
	output logic [1:0]       fault,          // fault code with done
	output logic             dst_we,         // write destination register
	output logic [31:0]      dst_data,       // destination value
	output logic             mem_we,         // memory write request
	output logic [31:0]      mem_addr,       // memory write address
	output logic [31:0]      mem_wdata,      // memory write data
	output logic             cache_enabled   // data cache enabled
);
	localparam logic [1:0] SUPERVISOR = 2'h1;

	dccu_state_e  state_r;
	logic [TAG_BITS-1:0]   tag_r   [SETS];
	logic [WORDS-1:0]      wval_r  [SETS];
	logic [31:0]           data_r  [SETS][WORDS];
	logic                  pend_r;
	logic [7:0]            code_r;
	logic [31:0]           addr_r, base_r;
	logic [SET_BITS-1:0]   set_r, end_r, fix_r;
	logic [2:0]            slot_r;
	logic                  inval_all;
	logic [15:0]           st_start, st_end_c;
	logic [31:0]           status_w;

	function automatic logic [SET_BITS-1:0] set_of(input logic [31:0] a);
		return a[SET_BITS+3:4];
	endfunction

	assign st_start = src_dst_in[15:0];
	assign st_end_c = (src_dst_in[31:16] >= 16'(SETS)) ? MAX_SET : src_dst_in[31:16];
	assign status_w = {4'h0, ST_WAYS_M1, ST_SETS_LOG, ST_LINE_LOG, ST_ATOM_LOG, 3'h0, cache_enabled};

	// issue is held in pend_r until earlier operations drain
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_r <= 1'b0;
		end else if (issue) begin
			pend_r <= 1'b1;
		end else if (state_r == S_IDLE && prior_idle) begin
			pend_r <= 1'b0;
		end
	end

	logic       go;
	logic [7:0] code_now;
	assign go       = pend_r && state_r == S_IDLE && prior_idle;
	assign code_now = code_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			code_r <= 8'h00;
			base_r <= 32'h0;
		end else if (issue) begin
			code_r <= function_code_operand[7:0];
			base_r <= target_address_operand;
		end
	end

	// main sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r       <= S_IDLE;
			busy          <= 1'b0;
			done          <= 1'b0;
			fault         <= FLT_NONE;
			dst_we        <= 1'b0;
			dst_data      <= 32'h0;
			cache_enabled <= 1'b0;
			inval_all     <= 1'b0;
			addr_r        <= 32'h0;
			set_r         <= '0;
			end_r         <= '0;
			slot_r        <= SLOT_SETDATA;
		end else begin
			done      <= 1'b0;
			dst_we    <= 1'b0;
			inval_all <= 1'b0;
			busy      <= pend_r || issue || state_r != S_IDLE;
			unique case (state_r)
				S_IDLE: if (go) begin
					fault <= FLT_NONE;
					if (execution_mode_field != SUPERVISOR) begin
						fault   <= FLT_TYPE;
						state_r <= S_DONE;
					end else begin
						state_r <= S_DONE;
						unique case (code_now)
							FN_DISABLE: cache_enabled <= 1'b0;
							FN_ENABLE:  cache_enabled <= 1'b1;
							FN_INVAL:   inval_all <= 1'b1;
							FN_COHERE:  inval_all <= 1'b1;
							FN_STATUS: begin
								dst_we   <= 1'b1;
								dst_data <= status_w;
							end
							FN_STORE: begin
								if ((base_r & ALIGN_MASK) != 32'h0 || st_start > st_end_c) begin
									fault <= FLT_OPERAND;
								end else begin
									addr_r  <= base_r;
									set_r   <= st_start[SET_BITS-1:0];
									end_r   <= st_end_c[SET_BITS-1:0];
									slot_r  <= SLOT_SETDATA;
									state_r <= S_WRITE;
								end
							end
							default: fault <= FLT_OPERAND;
						endcase
					end
				end
				S_WRITE: if (mem_we && mem_ready) begin
					addr_r <= addr_r + ADDR_STEP;
					if (slot_r == SLOT_LAST) begin
						slot_r <= SLOT_SETDATA;
						if (set_r == end_r) begin
							state_r <= S_FIX;
						end else begin
							set_r <= set_r + 8'h01;
						end
					end else begin
						slot_r <= slot_r + 3'h1;
					end
				end
				S_FIX: if (fix_r == MAX_SET[SET_BITS-1:0]) begin
					state_r <= S_DONE;
				end
				S_DONE: begin
					done    <= 1'b1;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// slot about to be presented; after the last slot a new set opens on its set data word
	logic [2:0] nslot;
	assign nslot = (mem_we && mem_ready) ? ((slot_r == SLOT_LAST) ? SLOT_SETDATA : slot_r + 3'h1) : slot_r;

	// memory write port; data reflects cache as held, fix-up runs after
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_we    <= 1'b0;
			mem_addr  <= 32'h0;
			mem_wdata <= 32'h0;
		end else if (state_r == S_WRITE && !(mem_we && mem_ready && slot_r == SLOT_LAST && set_r == end_r)) begin
			mem_we   <= 1'b1;
			mem_addr <= (mem_we && mem_ready) ? addr_r + ADDR_STEP : addr_r;
			unique case (nslot)
				SLOT_SETDATA: mem_wdata <= 32'h0; // direct mapped: no replacement data
				SLOT_TAG:     mem_wdata <= {{(32-TAG_BITS){1'b0}}, tag_r[set_r]};
				SLOT_VALID:   mem_wdata <= {28'h0, wval_r[set_r]};
				default:      mem_wdata <= data_r[set_r][WORD_BITS'(nslot - 3'h3)];
			endcase
		end else begin
			mem_we <= 1'b0;
		end
	end

	// sweep index for the coherency fix-up, one set per cycle
	always_ff @(posedge sys_clk) begin
		if (rst || state_r != S_FIX) begin
			fix_r <= '0;
		end else begin
			fix_r <= fix_r + 8'h01;
		end
	end

	// cache arrays, direct mapped, one line per set
	logic [31:0] fix_lo, fix_hi;
	assign fix_lo = base_r;
	assign fix_hi = addr_r;
	always_ff @(posedge sys_clk) begin
		for (int s = 0; s < SETS; s++) begin
			if (rst || inval_all) begin
				wval_r[s] <= '0;
			end else if (state_r == S_FIX && fix_r == SET_BITS'(s)) begin
				for (int w = 0; w < WORDS; w++) begin
					if ({tag_r[s], SET_BITS'(s), WORD_BITS'(w), 2'b00} >= fix_lo &&
					    {tag_r[s], SET_BITS'(s), WORD_BITS'(w), 2'b00} < fix_hi)
						wval_r[s][w] <= 1'b0;
				end
			end else if (fill_valid && cache_enabled && state_r == S_IDLE && set_of(fill_addr) == SET_BITS'(s)) begin
				if (tag_r[s] != fill_addr[31:32-TAG_BITS])
					wval_r[s] <= '0;
				wval_r[s][fill_addr[3:2]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (fill_valid && cache_enabled && state_r == S_IDLE) begin
			tag_r[set_of(fill_addr)]                   <= fill_addr[31:32-TAG_BITS];
			data_r[set_of(fill_addr)][fill_addr[3:2]] <= fill_data;
		end
	end

	priv_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field != SUPERVISOR) |=> ##1 (done && fault == FLT_TYPE && !mem_we))
		else $error("privilege fault not raised");
	status_word_a: assert property (@(posedge sys_clk) disable iff (rst)
		dst_we |-> (dst_data[31:1] == 31'h0000_4110 && dst_data[0] == cache_enabled))
		else $error("status word wrong");
	enable_fn_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field == SUPERVISOR && code_now == FN_ENABLE) |=> cache_enabled)
		else $error("enable not applied");
	disable_fn_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field == SUPERVISOR && code_now == FN_DISABLE) |=> !cache_enabled)
		else $error("disable not applied");
	cohere_inval_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field == SUPERVISOR && code_now == FN_COHERE) |=> inval_all)
		else $error("coherency did not invalidate");
	align_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field == SUPERVISOR && code_now == FN_STORE && base_r[1:0] != 2'b00)
		|=> ##1 (done && fault == FLT_OPERAND))
		else $error("misaligned store not faulted");
	addr_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		(mem_we && mem_ready ##1 mem_we) |-> mem_addr == $past(mem_addr) + ADDR_STEP)
		else $error("store address did not advance by four");
	undef_code_a: assert property (@(posedge sys_clk) disable iff (rst)
		(go && execution_mode_field == SUPERVISOR && code_now == 8'h05)
		|=> ##1 (done && fault == FLT_OPERAND && $stable(cache_enabled)))
		else $error("reserved code not faulted");
	order_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_r == S_WRITE) |-> busy)
		else $error("busy dropped during operation");
endmodule
`default_nettype wire

/* File: tb/dccu_mem_model.sv */
// external memory responder that records cache store writes
`timescale 1ns/1ps
`default_nettype none
module dccu_mem_model (
	input  wire logic        sys_clk,   // core clock
	input  wire logic        slow,      // accept every other cycle
	input  wire logic        mem_we,    // write request
	input  wire logic [31:0] mem_addr,  // write address
	input  wire logic [31:0] mem_wdata, // write data
	output logic             mem_ready  // write accepted
);
	logic [31:0] wa [0:255];
	logic [31:0] wd [0:255];
	int          n  = 0;
	logic        ph = 1'b0;
	// ready only while asked; slow mode stalls alternate cycles
	assign mem_ready = mem_we & (~slow | ph);
	always @(posedge sys_clk) begin
		ph <= ~ph;
		if (mem_we && mem_ready) begin
			wa[n] <= mem_addr;
			wd[n] <= mem_wdata;
			n <= n + 1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the data cache control unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dccu_pkg::*;
	logic        sys_clk = 0, rst = 1, issue = 0, prior_idle = 1, fill_valid = 0, slow = 0;
	logic [1:0]  mode = 2'h1, fault, flt;
	logic [31:0] fn = 0, tgt = 0, sd = 0, fa = 0, fd = 0, st, dst_data, mem_addr, mem_wdata;
	logic        busy, done, dst_we, mem_we, mem_ready, cache_enabled;
	logic [7:0]  und [5] = '{8'h05, 8'h07, 8'h08, 8'h09, 8'hff};
	int          error_cnt = 0, checks = 0, n0, i;
	always #25 sys_clk = ~sys_clk;
	dccu_top i_dccu_top(.sys_clk(sys_clk), .rst(rst), .issue(issue), .execution_mode_field(mode),
		.function_code_operand(fn), .target_address_operand(tgt), .src_dst_in(sd),
		.prior_idle(prior_idle), .fill_valid(fill_valid), .fill_addr(fa), .fill_data(fd),
		.mem_ready(mem_ready), .busy(busy), .done(done), .fault(fault), .dst_we(dst_we),
		.dst_data(dst_data), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.cache_enabled(cache_enabled));
	dccu_mem_model i_dccu_mem_model(.sys_clk(sys_clk), .slow(slow), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic go(input logic [31:0] f, input logic [31:0] t, input logic [31:0] s);
		@(posedge sys_clk);
		issue <= 1'b1;
		fn <= f;
		tgt <= t;
		sd <= s;
		n0 = i_dccu_mem_model.n;
		@(posedge sys_clk);
		issue <= 1'b0;
	endtask
	// src_dst_in is held after issue since the store reads it only when it starts, not at issue
	task automatic fin;
		int k;
		for (k = 0; k < 3000; k++) begin
			#1;
			if (dst_we === 1'b1) st = dst_data;
			if (done === 1'b1) break;
			@(posedge sys_clk);
		end
		flt = fault;
		if (k == 3000) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task automatic op(input logic [31:0] f, input logic [31:0] t, input logic [31:0] s);
		go(f, t, s);
		fin();
	endtask
	task automatic fill(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		fill_valid <= 1'b1;
		fa <= a;
		fd <= d;
		@(posedge sys_clk);
		fill_valid <= 1'b0;
	endtask
	task automatic t_codes;
		mode <= 2'h0;
		op(FN_ENABLE, 0, 0);
		chk("priv fault", flt, FLT_TYPE);
		chk("priv no op", cache_enabled, 0);
		mode <= 2'h1;
		op(32'h0000_ff01, 0, 0);
		chk("enable", cache_enabled, 1);
		op(FN_STATUS, 0, 0);
		chk("status on", st, 32'h0000_8221);
		for (i = 0; i < 5; i++) begin
			op({24'h0, und[i]}, 0, 0);
			chk("undef fault", flt, FLT_OPERAND);
			chk("undef state", cache_enabled, 1);
		end
		op(FN_DISABLE, 0, 0);
		chk("disable", cache_enabled, 0);
		op(FN_STATUS, 0, 0);
		chk("status off", st, 32'h0000_8220);
		$display("test codes done");
	endtask
	task automatic t_order;
		prior_idle <= 1'b0;
		go(FN_ENABLE, 0, 0);
		repeat (5) @(posedge sys_clk);
		#1;
		chk("held busy", busy, 1);
		chk("held done", done, 0);
		prior_idle <= 1'b1;
		fin();
		chk("late enable", cache_enabled, 1);
		$display("test order done");
	endtask
	task automatic dump(input logic [31:0] t, input logic [31:0] s, input int cnt, input logic [31:0] vb);
		op(FN_STORE, t, s);
		@(posedge sys_clk);
		chk("store fault", flt, FLT_NONE);
		chk("write count", i_dccu_mem_model.n - n0, cnt);
		for (i = 0; i < cnt; i++)
			chk("write addr", i_dccu_mem_model.wa[n0 + i], t + 4 * i);
		chk("set data", i_dccu_mem_model.wd[n0], 0);
		chk("valid bits", i_dccu_mem_model.wd[n0 + 2] & 32'hf, vb);
	endtask
	task automatic t_store;
		slow <= 1'b1;
		fill(32'h0000_1014, 32'ha5a5_0001);
		dump(32'h1000_0000, 32'h0002_0001, 14, 2);
		chk("line word", i_dccu_mem_model.wd[n0 + 4], 32'ha5a5_0001);
		chk("tag word", i_dccu_mem_model.wd[n0 + 1], 32'h0000_0001);
		chk("next set data", i_dccu_mem_model.wd[n0 + 7], 32'h0000_0000);
		dump(32'h0000_1010, 32'h0001_0001, 7, 2);
		dump(32'h2000_0000, 32'h0001_0001, 7, 0);
		dump(32'h3000_0000, 32'hffff_00ff, 7, 0);
		op(FN_STORE, 32'h1000_0002, 32'h0001_0001);
		chk("misaligned", flt, FLT_OPERAND);
		op(FN_STORE, 32'h1000_0000, 32'h0002_0003);
		chk("start past end", flt, FLT_OPERAND);
		chk("no writes", i_dccu_mem_model.n - n0, 0);
		for (int c = 2; c < 4; c++) begin
			fill(32'h0000_0018, 32'h0000_5a5a);
			op(c, 0, 0);
			dump(32'h4000_0000, 32'h0001_0001, 7, 0);
		end
		$display("test store done");
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_codes();
		t_order();
		t_store();
		wrap_up();
	end
endmodule
`default_nettype wire
